// >>> src/gpint_port.sv
// 64 pin general purpose port with seven interrupt capable pins
// Summary of operation
// - an input pin's sampled level is copied into its data bit.
// - an output pin is driven with its data bit.
// - direction bit 0 means input and 1 output, low word pins 0-31.
// - data bit n of the low word is pin n, of the high word pin 32+n.
// - setup bits 6:0 make pins 48-54 interrupt inputs when set.
// - setup bits 22:16 choose edge (0) or level (1) detection.
// - setup bits 14:8 choose low/falling (0) or high/rising (1).
// - a selected event sets the pin's flag in bits 22:16 until cleared.
// - flags read and clear writes share one address.
// - writing 1 to a clear bit drops its flag unless an event sets it that cycle, 0 leaves it alone.
// - all data, direction, setup and flag registers reset to zero.
`timescale 1ns/1ps
`default_nettype none
module gpint_port
    import gpint_pkg::*;
#(
    parameter int unsigned PINS = GPINT_PINS
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        reg_req_i,
    input  wire logic        reg_wr_i,
    input  wire logic [23:0] reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    output var  logic [31:0] reg_rdata_o,
    output var  logic        reg_ack_o,
    input  wire logic [63:0] pin_in_i,
    output var  logic [63:0] pin_out_o,
    output var  logic [63:0] pin_oe_o,
    output var  logic        irq_o
);

    if (PINS != 2 * GPINT_WORD) begin : g_pins_check
        $error("gpint_port serves exactly 64 pins");
    end

    function automatic logic hit(input logic [23:0] a,
                                 input logic [23:0] off);
        hit = (a[23:2] == off[23:2]);
    endfunction

    logic [63:0] sync1_q;
    logic [63:0] sync2_q;
    logic [63:0] data_q;
    logic [63:0] dir_q;
    logic [6:0]  en_q;
    logic [6:0]  act_q;
    logic [6:0]  trig_q;
    logic [31:0] rdata_q;
    logic        ack_q;
    logic        irq_q;
    logic        wr_req;
    logic        rd_req;
    logic [31:0] rdata_d;

    gpint_irq_if irq_bus ();

    assign wr_req = reg_req_i & reg_wr_i;
    assign rd_req = reg_req_i & ~reg_wr_i;

    // two stage synchroniser, first stage read only by the second
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sync1_q <= GPINT_RST_PINS;
            sync2_q <= GPINT_RST_PINS;
        end else begin
            sync1_q <= pin_in_i;
            sync2_q <= sync1_q;
        end
    end

    // data words: inputs follow the pin, outputs keep written value
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            data_q <= GPINT_RST_PINS;
        end else begin
            for (int i = 0; i < 64; i++) begin
                if (!dir_q[i]) begin
                    data_q[i] <= sync2_q[i];
                end else if (wr_req && hit(reg_addr_i, GPINT_OFF_DATA_LO)
                             && i < 32) begin
                    data_q[i] <= reg_wdata_i[i % 32];
                end else if (wr_req && hit(reg_addr_i, GPINT_OFF_DATA_HI)
                             && i >= 32) begin
                    data_q[i] <= reg_wdata_i[i % 32];
                end
            end
        end
    end

    // direction words
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            dir_q <= GPINT_RST_PINS;
        end else if (wr_req && hit(reg_addr_i, GPINT_OFF_DIR_LO)) begin
            dir_q[31:0] <= reg_wdata_i;
        end else if (wr_req && hit(reg_addr_i, GPINT_OFF_DIR_HI)) begin
            dir_q[63:32] <= reg_wdata_i;
        end
    end

    // interrupt setup word
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            en_q   <= GPINT_RST_FIELD;
            act_q  <= GPINT_RST_FIELD;
            trig_q <= GPINT_RST_FIELD;
        end else if (wr_req && hit(reg_addr_i, GPINT_OFF_SETUP)) begin
            en_q   <= reg_wdata_i[GPINT_EN_LSB +: 7];
            act_q  <= reg_wdata_i[GPINT_ACT_LSB +: 7];
            trig_q <= reg_wdata_i[GPINT_TRIG_LSB +: 7];
        end
    end

    // detector hookup; writes at the flag address only clear
    assign irq_bus.en   = en_q;
    assign irq_bus.act  = act_q;
    assign irq_bus.trig = trig_q;
    assign irq_bus.pin  = sync2_q[GPINT_IRQ_FIRST +: 7];
    assign irq_bus.clr  = (wr_req && hit(reg_addr_i, GPINT_OFF_FLAGS)) ?
                          reg_wdata_i[GPINT_FLAG_LSB +: 7] :
                          GPINT_RST_FIELD;

    gpint_irq_detect u_detect (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .irq       (irq_bus.det)
    );

    // read mux, unmapped and reserved bits read zero
    always_comb begin
        rdata_d = GPINT_RST_WORD;
        if (hit(reg_addr_i, GPINT_OFF_DATA_LO)) begin
            rdata_d = data_q[31:0];
        end else if (hit(reg_addr_i, GPINT_OFF_DATA_HI)) begin
            rdata_d = data_q[63:32];
        end else if (hit(reg_addr_i, GPINT_OFF_DIR_LO)) begin
            rdata_d = dir_q[31:0];
        end else if (hit(reg_addr_i, GPINT_OFF_DIR_HI)) begin
            rdata_d = dir_q[63:32];
        end else if (hit(reg_addr_i, GPINT_OFF_SETUP)) begin
            rdata_d[GPINT_EN_LSB +: 7]   = en_q;
            rdata_d[GPINT_ACT_LSB +: 7]  = act_q;
            rdata_d[GPINT_TRIG_LSB +: 7] = trig_q;
        end else if (hit(reg_addr_i, GPINT_OFF_FLAGS)) begin
            rdata_d[GPINT_FLAG_LSB +: 7] = irq_bus.status;
        end
    end

    // answer one cycle after every request
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ack_q   <= 1'b0;
            rdata_q <= GPINT_RST_WORD;
        end else begin
            ack_q <= reg_req_i;
            if (rd_req) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // interrupt line follows the next flag value
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |irq_bus.status_nx;
        end
    end

    assign reg_ack_o   = ack_q;
    assign reg_rdata_o = rdata_q;
    assign pin_out_o   = data_q;
    assign pin_oe_o    = dir_q;
    assign irq_o       = irq_q;

    // checks
    pin_sample_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ##3 (((data_q ^ $past(pin_in_i, 3)) & ~$past(dir_q)
              & ~dir_q) == 64'h0))
        else $error("input data bit does not follow the pin");

    pin_drive_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr_req && hit(reg_addr_i, GPINT_OFF_DATA_LO)) |=>
            (((pin_out_o[31:0] ^ $past(reg_wdata_i)) & $past(dir_q[31:0]))
             == 32'h0))
        else $error("output pin not driven with written data");

    dir_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr_req && hit(reg_addr_i, GPINT_OFF_DIR_HI)) |=>
            (pin_oe_o[63:32] == $past(reg_wdata_i)))
        else $error("high direction write not applied");

    irq_line_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        irq_o == (irq_bus.status != 7'h00))
        else $error("interrupt line disagrees with the flags");

    flag_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (rd_req && hit(reg_addr_i, GPINT_OFF_FLAGS)) |=>
            (reg_ack_o && reg_rdata_o == {9'h000, $past(irq_bus.status),
                                           16'h0000}))
        else $error("flag read returned wrong word");

    flag_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr_req && hit(reg_addr_i, GPINT_OFF_FLAGS)) |=>
            ($stable(en_q) && $stable(dir_q)))
        else $error("clear write disturbed other registers");

    setup_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (rd_req && hit(reg_addr_i, GPINT_OFF_SETUP)) |=>
            (reg_rdata_o[6:0] == $past(en_q) && reg_rdata_o[31:23] == 9'h000
             && !reg_rdata_o[15] && !reg_rdata_o[7]))
        else $error("setup read back wrong");

    bus_ack_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_ack_o == $past(reg_req_i))
        else $error("request not answered in one cycle");

endmodule
`default_nettype wire

// >>> src/gpint_pkg.sv
// constants for the general purpose pin port with pin interrupts
package gpint_pkg;

    // register byte addresses on the host bus
    localparam int unsigned      GPINT_ADDR_W      = 24;
    localparam logic [23:0]      GPINT_OFF_DATA_LO = 24'h010000;
    localparam logic [23:0]      GPINT_OFF_DATA_HI = 24'h010004;
    localparam logic [23:0]      GPINT_OFF_DIR_LO  = 24'h010008;
    localparam logic [23:0]      GPINT_OFF_DIR_HI  = 24'h01000c;
    localparam logic [23:0]      GPINT_OFF_SETUP   = 24'h010010;
    localparam logic [23:0]      GPINT_OFF_FLAGS   = 24'h010014;

    // pin counts
    localparam int unsigned      GPINT_PINS        = 64;
    localparam int unsigned      GPINT_WORD        = 32;
    localparam int unsigned      GPINT_IRQ_FIRST   = 48;
    localparam int unsigned      GPINT_IRQ_PINS    = 7;

    // field positions inside setup and flag words
    localparam int unsigned      GPINT_EN_LSB      = 0;
    localparam int unsigned      GPINT_ACT_LSB     = 8;
    localparam int unsigned      GPINT_TRIG_LSB    = 16;
    localparam int unsigned      GPINT_FLAG_LSB    = 16;

    // values after reset
    localparam logic [31:0]      GPINT_RST_WORD    = 32'h00000000;
    localparam logic [6:0]       GPINT_RST_FIELD   = 7'h00;
    localparam logic [63:0]      GPINT_RST_PINS    = 64'h0;

    // synchroniser depth in cycles
    localparam int unsigned      GPINT_SYNC_CYC    = 2;

endpackage

// >>> src/gpint_irq_if.sv
// signals between the register file and the interrupt detector
`timescale 1ns/1ps
`default_nettype none
interface gpint_irq_if;
    logic [6:0] en;
    logic [6:0] act;
    logic [6:0] trig;
    logic [6:0] pin;
    logic [6:0] clr;
    logic [6:0] status;
    logic [6:0] status_nx;

    modport ctl (
        output en,
        output act,
        output trig,
        output pin,
        output clr,
        input  status,
        input  status_nx
    );

    modport det (
        input  en,
        input  act,
        input  trig,
        input  pin,
        input  clr,
        output status,
        output status_nx
    );
endinterface
`default_nettype wire

// >>> src/gpint_irq_detect.sv
// edge or level detection and sticky flags for the interrupt pins
`timescale 1ns/1ps
`default_nettype none
module gpint_irq_detect
    import gpint_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    gpint_irq_if.det  irq
);

    logic [6:0] prev_q;
    logic [6:0] flag_q;
    logic [6:0] set_d;
    logic [6:0] flag_d;
    logic [6:0] rise_hit;
    logic [6:0] level_hit;

    // previous synchronised level for edges
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            prev_q <= GPINT_RST_FIELD;
        end else begin
            prev_q <= irq.pin;
        end
    end

    // event select per pin
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (irq.trig[i]) begin
                set_d[i] = irq.act[i] ? irq.pin[i] : ~irq.pin[i];
            end else if (irq.act[i]) begin
                set_d[i] = irq.pin[i] & ~prev_q[i];
            end else begin
                set_d[i] = ~irq.pin[i] & prev_q[i];
            end
        end
        set_d = set_d & irq.en;
    end

    // set wins over a clear in the same cycle
    assign flag_d = (flag_q & ~irq.clr) | set_d;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            flag_q <= GPINT_RST_FIELD;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign irq.status    = flag_q;
    assign irq.status_nx = flag_d;

    // checks
    assign rise_hit  = irq.en & ~irq.trig & irq.act & irq.pin & ~prev_q;
    assign level_hit = irq.en & irq.trig & ~irq.act & ~irq.pin;

    edge_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (rise_hit != 7'h00) |=> ((flag_q & $past(rise_hit)) == $past(rise_hit)))
        else $error("rising edge did not set its flag");

    level_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (level_hit != 7'h00) |=> ((flag_q & $past(level_hit)) == $past(level_hit)))
        else $error("active low level did not set its flag");

    flag_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ##1 (($past(flag_q) & ~$past(irq.clr) & ~flag_q) == 7'h00))
        else $error("flag dropped without a clear");

    flag_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ((irq.clr & ~set_d) != 7'h00) |=>
            ((flag_q & $past(irq.clr & ~set_d)) == 7'h00))
        else $error("clear did not drop the flag");

    flag_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ##1 ((flag_q & ~$past(flag_q) & ~$past(irq.en)) == 7'h00))
        else $error("flag set on a pin not enabled for interrupts");

endmodule
`default_nettype wire

// >>> testbench/gpint_pin_model.sv
// external devices on the pins, echoing driven pins back
`timescale 1ns/1ps
`default_nettype none
module gpint_pin_model (
    input  wire logic [63:0] pin_out_i,
    input  wire logic [63:0] pin_oe_i,
    input  wire logic [63:0] ext_lvl_i,
    output var  logic [63:0] pin_lvl_o
);
    // a driven pin reads back its drive, others follow the device
    always_comb begin
        pin_lvl_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_lvl_i);
    end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the pin port
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import gpint_pkg::*;
;
    logic        ref_clk_i   = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic        req         = 1'b0;
    logic        wr          = 1'b0;
    logic [23:0] addr        = 24'h000000;
    logic [31:0] wdata       = 32'h00000000;
    logic [31:0] rdata;
    logic        ack;
    logic [63:0] ext         = 64'h0;
    logic [63:0] lvl;
    logic [63:0] pout;
    logic [63:0] poe;
    logic        irq;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    always #50 ref_clk_i = ~ref_clk_i;

    gpint_port #(.PINS(GPINT_PINS)) u_dut (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .reg_req_i   (req),
        .reg_wr_i    (wr),
        .reg_addr_i  (addr),
        .reg_wdata_i (wdata),
        .reg_rdata_o (rdata),
        .reg_ack_o   (ack),
        .pin_in_i    (lvl),
        .pin_out_o   (pout),
        .pin_oe_o    (poe),
        .irq_o       (irq)
    );

    gpint_pin_model u_ext (
        .pin_out_i (pout),
        .pin_oe_i  (poe),
        .ext_lvl_i (ext),
        .pin_lvl_o (lvl)
    );

    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: word %h, want %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: bit %b, want %b", $time, got, exp);
        end
    endtask

    // one-cycle request, answer expected exactly one cycle later
    task automatic access(input logic w, input logic [23:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        req <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk_i);
        req <= 1'b0;
        do begin
            @(negedge ref_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 4);
        q = rdata;
        chk_bit(n == 1, 1'b1);
    endtask

    task automatic wr_reg(input logic [23:0] a, input logic [31:0] d);
        logic [31:0] q;
        access(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [23:0] a, input logic [31:0] exp);
        logic [31:0] q;
        access(1'b0, a, 32'h00000000, q);
        chk_word(q, exp);
    endtask

    task automatic pin_set(input int p, input logic v);
        @(posedge ref_clk_i);
        ext[p] <= v;
        repeat (5) @(posedge ref_clk_i);
    endtask

    task automatic sc_reset();
        for (int i = 0; i < 7; i++) begin
            rd_chk(24'h010000 + 24'(4 * i), 32'h00000000);
        end
        chk_word(poe[31:0] | poe[63:32], 32'h00000000);
        chk_bit(irq, 1'b0);
    endtask

    task automatic sc_dir();
        @(posedge ref_clk_i);
        ext[31:0] <= 32'h12345678;
        wr_reg(GPINT_OFF_DIR_LO, 32'hffff0000);
        wr_reg(GPINT_OFF_DATA_LO, 32'hbeef0000);
        wr_reg(GPINT_OFF_DIR_HI, 32'h0000ffff);
        wr_reg(GPINT_OFF_DATA_HI, 32'h00004321);
        repeat (4) @(posedge ref_clk_i);
        chk_word(poe[31:0], 32'hffff0000);
        chk_word(poe[63:32], 32'h0000ffff);
        chk_word(pout[31:0] & 32'hffff0000, 32'hbeef0000);
        chk_word({16'h0, pout[47:32]}, 32'h00004321);
        rd_chk(GPINT_OFF_DATA_LO, 32'hbeef5678);
        rd_chk(GPINT_OFF_DATA_HI, 32'h00004321);
    endtask

    task automatic sc_irq();
        @(posedge ref_clk_i);
        ext[49] <= 1'b1;
        ext[51] <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        // pins 48-51: rise, fall, high level, low level
        wr_reg(GPINT_OFF_SETUP, 32'h000c050f);
        rd_chk(GPINT_OFF_FLAGS, 32'h00000000);
        @(posedge ref_clk_i);
        ext[48] <= 1'b1;
        repeat (2) @(negedge ref_clk_i);
        chk_bit(irq, 1'b0);
        repeat (2) @(negedge ref_clk_i);
        chk_bit(irq, 1'b1);
        pin_set(48, 1'b0);
        rd_chk(GPINT_OFF_FLAGS, 32'h00010000);
        pin_set(52, 1'b1);
        pin_set(52, 1'b0);
        rd_chk(GPINT_OFF_FLAGS, 32'h00010000);
        pin_set(49, 1'b0);
        rd_chk(GPINT_OFF_FLAGS, 32'h00030000);
        pin_set(50, 1'b1);
        pin_set(51, 1'b0);
        rd_chk(GPINT_OFF_FLAGS, 32'h000f0000);
        wr_reg(GPINT_OFF_FLAGS, 32'h00050000);
        rd_chk(GPINT_OFF_FLAGS, 32'h000e0000);
        pin_set(50, 1'b0);
        pin_set(51, 1'b1);
        wr_reg(GPINT_OFF_FLAGS, 32'h007f0000);
        rd_chk(GPINT_OFF_FLAGS, 32'h00000000);
        repeat (2) @(negedge ref_clk_i);
        chk_bit(irq, 1'b0);
        rd_chk(GPINT_OFF_SETUP, 32'h000c050f);
    endtask

    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        sc_reset();
        sc_dir();
        sc_irq();
        print_verdict();
    end
endmodule
`default_nettype wire
